/* File: design/sucr_params.svh */
/*
 * Offsets, reset values, field positions and timing counts for the
 * sensor user configuration register bank.
 * Assumes inclusion by bare name from the package and design modules.
 */
`ifndef SUCR_PARAMS_SVH
`define SUCR_PARAMS_SVH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define SUCR_OFS_RESHTR 8'h00
`define SUCR_OFS_AUXV 8'h04
`define SUCR_OFS_HTRPWR 8'h08
`define SUCR_OFS_IRQ_STAT 8'h0c
`define SUCR_OFS_IRQ_CLR 8'h10
`define SUCR_OFS_IRQ_EN 8'h14
`define SUCR_OFS_STATUS 8'h18

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SUCR_RST_RESHTR 8'h3a
`define SUCR_RST_AUXV 8'h08
`define SUCR_RST_HTRPWR 8'h00

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SUCR_B_RES_HI 7
`define SUCR_B_SUPPLY_LOW 6
`define SUCR_B_HEATER_ON 2
`define SUCR_B_RES_LO 0
`define SUCR_B_MODE_HI 6
`define SUCR_B_MODE_LO 5
`define SUCR_B_CONV_SPEED 4
`define SUCR_B_IN_BUF 2
`define SUCR_B_REF_SEL 1
`define SUCR_B_PIN_LVL 0
`define SUCR_HTR_LVL_HI 3

// Writable mask of the first register: bit 6 is read-only
`define SUCR_MASK_RESHTR 8'hbf

// Interrupt bits
`define SUCR_IRQ_SUPPLY_LOW 0
`define SUCR_IRQ_CONV_DONE 1
`define SUCR_IRQ_W 2

// ----------------------------------------
// Timing
// ----------------------------------------
`define SUCR_CLK_HZ 50000000
`define SUCR_CONV_SLOW_US 7000
`define SUCR_CONV_FAST_US 3100
`define SUCR_CONV_SLOW_CYC ((`SUCR_CONV_SLOW_US * (`SUCR_CLK_HZ / 1000000)))
`define SUCR_CONV_FAST_CYC ((`SUCR_CONV_FAST_US * (`SUCR_CLK_HZ / 1000000)))

`endif

/* File: design/sucr_pkg.sv */
/*
 * Types shared by the register bank and its conversion timer.
 * Assumes sucr_params.svh is on the include path.
 */
package sucr_pkg;
	`include "sucr_params.svh"

	typedef enum logic [1:0] {
		SUCR_MODE_HOLD_RAW,
		SUCR_MODE_HOLD_CORR,
		SUCR_MODE_NOHOLD_RAW,
		SUCR_MODE_NOHOLD_CORR
	} sucr_mode_t;

	typedef enum logic [1:0] {
		SUCR_RES_12_14,
		SUCR_RES_8_12,
		SUCR_RES_10_13,
		SUCR_RES_11_11
	} sucr_res_t;

	// True for modes 10 and 11
	function automatic logic sucr_is_nohold(input sucr_mode_t m);
		return m[1];
	endfunction

	// True for modes 01 and 11
	function automatic logic sucr_is_corr(input sucr_mode_t m);
		return m[0];
	endfunction
endpackage

/* File: design/sucr_conv_if.sv */
/*
 * Handshake between the register bank and its conversion timer.
 * Assumes both ends share CLK_SYS.
 */
`timescale 1ns/1ns
interface sucr_conv_if;
	logic start;
	logic fast;
	logic busy;
	logic done;

	modport bank (output start, output fast, input busy, input done);
	modport timer (input start, input fast, output busy, output done);
endinterface

/* File: design/sucr_conv_timer.sv */
/*
 * Auxiliary converter timer: holds busy for the conversion time chosen
 * by the speed bit, then pulses done.
 * Assumes a synchronous active-high reset on the shared clock.
 */
`timescale 1ns/1ns
`include "sucr_params.svh"

module sucr_conv_timer
	import sucr_pkg::*;
#(
	parameter int unsigned SLOW_CYC = `SUCR_CONV_SLOW_CYC,
	parameter int unsigned FAST_CYC = `SUCR_CONV_FAST_CYC
) (
	input wire logic clk,
	input wire logic rst,
	sucr_conv_if.timer conv
);
	logic [31:0] cnt_q;
	logic busy_q;
	logic done_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_q <= 32'h0;
			busy_q <= 1'b0;
		end else if (!busy_q && conv.start) begin
			cnt_q <= conv.fast ? FAST_CYC - 32'h1 : SLOW_CYC - 32'h1;
			busy_q <= 1'b1;
		end else if (busy_q && cnt_q == 32'h0) begin
			busy_q <= 1'b0;
		end else if (busy_q) begin
			cnt_q <= cnt_q - 32'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			done_q <= 1'b0;
		end else begin
			done_q <= busy_q && cnt_q == 32'h0;
		end
	end

	assign conv.busy = busy_q;
	assign conv.done = done_q;
endmodule

/* File: design/sucr_regs.sv */
/*
 * User configuration register bank of a humidity and temperature sensor,
 * reached over AHB-Lite, with interrupt status and a converter timer.
 * Assumes a single AHB-Lite master, word-only transfers, and that the
 * supply-low and address-strap levels arrive asynchronously from pins.
 */
`timescale 1ns/1ns
`include "sucr_params.svh"

module sucr_regs
	import sucr_pkg::*;
#(
	parameter int unsigned SLOW_CYC = `SUCR_CONV_SLOW_CYC,
	parameter int unsigned FAST_CYC = `SUCR_CONV_FAST_CYC
) (
	// Clock and reset
	input wire logic CLK_SYS,
	input wire logic SYS_RST,
	// AHB-Lite slave
	input wire logic HSEL,
	input wire logic [7:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	// Sensor side inputs
	input wire logic SUPPLY_LOW_IN,
	input wire logic ADDR_STRAP_IN,
	input wire logic MEAS_REQ,
	input wire logic MEAS_NOHOLD_CMD,
	// Configuration outputs
	output logic [1:0] RESOLUTION_SEL,
	output logic HEATER_ON,
	output logic [3:0] HEATER_LEVEL,
	output logic HEATER_DRIVE_EN,
	output logic [1:0] VOLT_MEAS_MODE,
	output logic THERM_CORR_EN,
	output logic MEAS_NOHOLD,
	output logic ADC_CONV_SPEED,
	output logic AUX_INPUT_BUFFER_EN,
	output logic ADC_REF_SELECT,
	output logic AUX_PIN_LEVEL,
	output logic AUX_PIN_OE,
	output logic ADDR_LSB_SELECT,
	output logic CONV_BUSY,
	// Interrupt
	output logic IRQ
);
	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	logic sl_meta_q, sl_sync_q, sl_prev_q;
	logic st_meta_q, st_sync_q;
	logic strap_taken_q;

	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			sl_meta_q <= 1'b0;
			sl_sync_q <= 1'b0;
			sl_prev_q <= 1'b0;
		end else begin
			sl_meta_q <= SUPPLY_LOW_IN;
			sl_sync_q <= sl_meta_q;
			sl_prev_q <= sl_sync_q;
		end
	end

	// Strap flops run through reset so the capture after release sees the pin
	always_ff @(posedge CLK_SYS) begin
		st_meta_q <= ADDR_STRAP_IN;
		st_sync_q <= st_meta_q;
	end

	// ----------------------------------------
	// Address strap capture
	// ----------------------------------------
	// strap read once, in the first cycle after each reset release
	logic strap_q;
	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			strap_taken_q <= 1'b0;
			strap_q <= 1'b0;
		end else if (!strap_taken_q) begin
			strap_taken_q <= 1'b1;
			strap_q <= st_sync_q;
		end
	end

	// ----------------------------------------
	// AHB-Lite address phase
	// ----------------------------------------
	logic ap_wr_q, ap_rd_q;
	logic [7:0] ap_addr_q;
	logic ap_valid;

	assign ap_valid = HSEL && HREADY && HTRANS[1];

	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			ap_wr_q <= 1'b0;
			ap_rd_q <= 1'b0;
			ap_addr_q <= 8'h00;
		end else begin
			ap_wr_q <= ap_valid && HWRITE;
			ap_rd_q <= ap_valid && !HWRITE;
			if (ap_valid) begin
				ap_addr_q <= HADDR;
			end
		end
	end

	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		return a[7:2] == ofs[7:2];
	endfunction

	logic wr_reshtr, wr_auxv, wr_htrpwr, wr_iclr, wr_ien;
	assign wr_reshtr = ap_wr_q && hit(ap_addr_q, `SUCR_OFS_RESHTR);
	assign wr_auxv = ap_wr_q && hit(ap_addr_q, `SUCR_OFS_AUXV);
	assign wr_htrpwr = ap_wr_q && hit(ap_addr_q, `SUCR_OFS_HTRPWR);
	assign wr_iclr = ap_wr_q && hit(ap_addr_q, `SUCR_OFS_IRQ_CLR);
	assign wr_ien = ap_wr_q && hit(ap_addr_q, `SUCR_OFS_IRQ_EN);

	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------
	logic [7:0] reshtr_q, auxv_q, htrpwr_q;

	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			reshtr_q <= `SUCR_RST_RESHTR;
		end else if (wr_reshtr) begin
			reshtr_q <= HWDATA[7:0] & `SUCR_MASK_RESHTR;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			auxv_q <= `SUCR_RST_AUXV;
		end else if (wr_auxv) begin
			auxv_q <= HWDATA[7:0];
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			htrpwr_q <= `SUCR_RST_HTRPWR;
		end else if (wr_htrpwr) begin
			htrpwr_q <= HWDATA[7:0];
		end
	end

	// ----------------------------------------
	// Decoded controls
	// ----------------------------------------
	sucr_mode_t mode;
	assign mode = sucr_mode_t'(auxv_q[`SUCR_B_MODE_HI:`SUCR_B_MODE_LO]);

	// resolution from bits 7 and 0
	assign RESOLUTION_SEL = {reshtr_q[`SUCR_B_RES_HI], reshtr_q[`SUCR_B_RES_LO]};
	assign HEATER_ON = reshtr_q[`SUCR_B_HEATER_ON];
	assign HEATER_LEVEL = htrpwr_q[`SUCR_HTR_LVL_HI:0];
	assign HEATER_DRIVE_EN = reshtr_q[`SUCR_B_HEATER_ON];
	assign VOLT_MEAS_MODE = mode;
	assign THERM_CORR_EN = sucr_is_corr(mode);
	assign MEAS_NOHOLD = sucr_is_nohold(mode) || MEAS_NOHOLD_CMD;
	assign ADC_CONV_SPEED = auxv_q[`SUCR_B_CONV_SPEED];
	assign AUX_INPUT_BUFFER_EN = auxv_q[`SUCR_B_IN_BUF];
	assign ADC_REF_SELECT = auxv_q[`SUCR_B_REF_SEL];
	// pin level, driven once strap taken
	assign AUX_PIN_LEVEL = auxv_q[`SUCR_B_PIN_LVL];
	assign AUX_PIN_OE = strap_taken_q;
	assign ADDR_LSB_SELECT = strap_q;

	// ----------------------------------------
	// Conversion timer
	// ----------------------------------------
	sucr_conv_if conv ();
	assign conv.start = MEAS_REQ;
	assign conv.fast = auxv_q[`SUCR_B_CONV_SPEED];
	assign CONV_BUSY = conv.busy;

	sucr_conv_timer #(
		.SLOW_CYC(SLOW_CYC),
		.FAST_CYC(FAST_CYC)
	) u_timer (
		.clk(CLK_SYS),
		.rst(SYS_RST),
		.conv(conv)
	);

	// ----------------------------------------
	// Interrupts
	// ----------------------------------------
	logic [`SUCR_IRQ_W-1:0] istat_q, ien_q, iev;

	// flag rises on 0-to-1 supply transition
	assign iev = {conv.done, sl_sync_q && !sl_prev_q};

	// Set wins over a clear in the same cycle
	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			istat_q <= '0;
		end else begin
			istat_q <= (istat_q & ~(wr_iclr ? HWDATA[`SUCR_IRQ_W-1:0] : '0)) | iev;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			ien_q <= '0;
		end else if (wr_ien) begin
			ien_q <= HWDATA[`SUCR_IRQ_W-1:0];
		end
	end

	assign IRQ = |(istat_q & ien_q);

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	logic [7:0] rd_d;
	logic [31:0] rdata_q;

	always_comb begin
		rd_d = 8'h00;
		if (hit(HADDR, `SUCR_OFS_RESHTR)) begin
			rd_d = reshtr_q | ({7'h00, sl_sync_q} << `SUCR_B_SUPPLY_LOW);
		end else if (hit(HADDR, `SUCR_OFS_AUXV)) begin
			rd_d = auxv_q;
		end else if (hit(HADDR, `SUCR_OFS_HTRPWR)) begin
			rd_d = htrpwr_q;
		end else if (hit(HADDR, `SUCR_OFS_IRQ_STAT)) begin
			rd_d = {6'h00, istat_q};
		end else if (hit(HADDR, `SUCR_OFS_IRQ_EN)) begin
			rd_d = {6'h00, ien_q};
		end else if (hit(HADDR, `SUCR_OFS_STATUS)) begin
			rd_d = {6'h00, strap_q, conv.busy};
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (SYS_RST) begin
			rdata_q <= 32'h0;
		end else if (ap_valid && !HWRITE) begin
			rdata_q <= {24'h0, rd_d};
		end
	end

	assign HRDATA = rdata_q;
	assign HREADYOUT = 1'b1;
	assign HRESP = 1'b0;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	reset_value_a: assert property (@(posedge CLK_SYS)
		$fell(SYS_RST) |-> reshtr_q == `SUCR_RST_RESHTR && htrpwr_q == 8'h00)
		else $error("first or third register reset value wrong");
	aux_reset_a: assert property (@(posedge CLK_SYS)
		$fell(SYS_RST) |-> auxv_q[7:1] == 7'h04)
		else $error("second register reset value wrong");
	flag_readonly_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		wr_reshtr |=> reshtr_q[`SUCR_B_SUPPLY_LOW] == 1'b0)
		else $error("supply flag bit stored by a write");
	res_map_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		ap_wr_q && hit(ap_addr_q, `SUCR_OFS_RESHTR)
		|=> RESOLUTION_SEL == {$past(HWDATA[7]), $past(HWDATA[0])})
		else $error("resolution field not taken from bits 7 and 0");
	nohold_mode_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		mode[1] |-> MEAS_NOHOLD)
		else $error("no-hold mode did not force no-hold");
	corr_mode_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		wr_auxv |=> THERM_CORR_EN == $past(HWDATA[`SUCR_B_MODE_LO]))
		else $error("thermistor correction mismatched to mode");
	heater_gate_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		wr_reshtr && !HWDATA[`SUCR_B_HEATER_ON] |=> !HEATER_DRIVE_EN)
		else $error("heater drive active while disabled");
	supply_irq_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		sl_sync_q && !sl_prev_q |=> istat_q[`SUCR_IRQ_SUPPLY_LOW])
		else $error("supply-low event not latched");
	conv_len_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		conv.start && !conv.busy |=> conv.busy [*2])
		else $error("conversion ended too soon");
	pin_level_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		wr_auxv |=> AUX_PIN_LEVEL == $past(HWDATA[0]))
		else $error("pin level not following register bit");
	// Write-driven checks compare against the bus data, not the decode
	heater_switch_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		wr_reshtr |=> HEATER_ON == $past(HWDATA[`SUCR_B_HEATER_ON]))
		else $error("heater switch not following register bit");
	heater_level_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		wr_htrpwr |=> HEATER_LEVEL == $past(HWDATA[3:0]))
		else $error("heater level not following register field");
	level_reset_a: assert property (@(posedge CLK_SYS)
		$fell(SYS_RST) |-> HEATER_LEVEL == 4'h0 && !HEATER_DRIVE_EN)
		else $error("heater level or drive not cleared by reset");
	mode_field_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		wr_auxv |=> VOLT_MEAS_MODE == $past(HWDATA[`SUCR_B_MODE_HI:`SUCR_B_MODE_LO]))
		else $error("measurement mode not following register field");
	hold_mode_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		!VOLT_MEAS_MODE[1] && !MEAS_NOHOLD_CMD |-> !MEAS_NOHOLD)
		else $error("hold mode reported no-hold");
	raw_mode_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		!VOLT_MEAS_MODE[0] |-> !THERM_CORR_EN)
		else $error("raw mode applied thermistor correction");
	corr_nohold_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		VOLT_MEAS_MODE == 2'b11 |-> THERM_CORR_EN && MEAS_NOHOLD)
		else $error("mode 11 lacks correction or no-hold");
	speed_bit_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		wr_auxv |=> ADC_CONV_SPEED == $past(HWDATA[`SUCR_B_CONV_SPEED]))
		else $error("converter speed not following register bit");
	conv_done_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		$fell(conv.busy) |-> conv.done)
		else $error("conversion end not flagged");
	buffer_sel_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		wr_auxv |=> AUX_INPUT_BUFFER_EN == $past(HWDATA[`SUCR_B_IN_BUF]))
		else $error("input buffer select not following register bit");
	ref_sel_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		wr_auxv |=> ADC_REF_SELECT == $past(HWDATA[`SUCR_B_REF_SEL]))
		else $error("reference select not following register bit");
	supply_read_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		ap_valid && !HWRITE && hit(HADDR, `SUCR_OFS_RESHTR)
		|=> HRDATA[`SUCR_B_SUPPLY_LOW] == $past(sl_sync_q))
		else $error("supply flag read back wrong");
	irq_clear_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		wr_iclr && HWDATA[`SUCR_IRQ_SUPPLY_LOW] && !iev[`SUCR_IRQ_SUPPLY_LOW]
		|=> !istat_q[`SUCR_IRQ_SUPPLY_LOW])
		else $error("supply-low status not cleared");
	pin_drive_a: assert property (@(posedge CLK_SYS)
		$fell(SYS_RST) |-> !AUX_PIN_OE ##1 AUX_PIN_OE)
		else $error("pin driven before strap capture or not after");
endmodule

/* File: verif/sucr_host_model.sv */
/*
 * Host model: an AHB-Lite master that issues single word transfers.
 * Assumes hready is the one slave's hreadyout, fed back by the bench.
 */
`timescale 1ns/1ns
module sucr_host_model (
	// Bus clock
	input wire logic clk,
	// AHB-Lite master side
	output logic hsel,
	output logic [7:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata
);
	initial begin
		hsel = 1'b0;
		haddr = 8'h00;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
	end

	// reserved bits zero
	// Callers pass reserved bits as zero; read values are compared whole.
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		hsize <= 3'h2;
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk); while (hready !== 1'b1);
		rd = hrdata;
		// Released write data changes, so a stale value cannot pass
		hwdata <= ~wd;
	endtask
endmodule

/* File: verif/testbench.sv */
/*
 * Self-checking bench of the sensor user configuration register bank.
 * Assumes shortened conversion counts and a host model on the bus.
 */
`timescale 1ns/1ns
module testbench;
	import sucr_pkg::*;
	localparam int SLOW = 20;
	localparam int FAST = 10;
	logic clk_sys = 1'b0, sys_rst = 1'b1, sup_low = 1'b0, strap = 1'b1, req = 1'b0, nh_cmd = 1'b0;
	logic hsel, hwrite, hreadyout, hresp, heater_on, drive_en, corr, nohold, speed, buf_en, ref_sel;
	logic pin_lvl, pin_oe, lsb_sel, busy, irq;
	logic [7:0] haddr;
	logic [1:0] htrans, res_sel, mode;
	logic [2:0] hsize;
	logic [31:0] hwdata, hrdata, rdv;
	logic [3:0] htr_lvl;
	int miscompares = 0, comparisons = 0, cycles = 0;
	logic [3:0] lvls [6] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'hf};

	always #10 clk_sys = ~clk_sys;

	sucr_host_model sucr_host_model_inst (.clk(clk_sys), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata));

	sucr_regs #(.SLOW_CYC(SLOW), .FAST_CYC(FAST)) sucr_regs_inst (.CLK_SYS(clk_sys),
		.SYS_RST(sys_rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
		.HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
		.HREADYOUT(hreadyout), .HRESP(hresp), .SUPPLY_LOW_IN(sup_low), .ADDR_STRAP_IN(strap),
		.MEAS_REQ(req), .MEAS_NOHOLD_CMD(nh_cmd), .RESOLUTION_SEL(res_sel),
		.HEATER_ON(heater_on), .HEATER_LEVEL(htr_lvl), .HEATER_DRIVE_EN(drive_en),
		.VOLT_MEAS_MODE(mode), .THERM_CORR_EN(corr), .MEAS_NOHOLD(nohold),
		.ADC_CONV_SPEED(speed), .AUX_INPUT_BUFFER_EN(buf_en), .ADC_REF_SELECT(ref_sel),
		.AUX_PIN_LEVEL(pin_lvl), .AUX_PIN_OE(pin_oe), .ADDR_LSB_SELECT(lsb_sel),
		.CONV_BUSY(busy), .IRQ(irq));

	// ----------------
	// Helpers
	// ----------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		sucr_host_model_inst.xfer(1'b1, a, {24'h0, d}, rdv);
		#1;
	endtask

	task automatic rd(input logic [7:0] a);
		sucr_host_model_inst.xfer(1'b0, a, 32'h0, rdv);
		#1;
	endtask

	task automatic summarize();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Hang guard: the whole run needs well under a thousand cycles
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 4000) begin
			miscompares++;
			summarize();
		end
	end

	// ----------------
	// Scenarios
	// ----------------
	task automatic t_reset();
		rd(8'h00); check(rdv, 32'h3a);
		rd(8'h04); check(rdv, 32'h08);
		rd(8'h08); check(rdv, 32'h00);
		wr(8'h1c, 8'hff); rd(8'h1c); check(rdv, 32'h0);
		rd(8'h18); check(rdv, 32'h2);
		check({hresp, pin_oe, lsb_sel}, 3'b011);
		$display("reset test done");
	endtask

	task automatic t_res_heater();
		for (int r = 0; r < 4; r++) begin
			wr(8'h00, {r[1], 6'h0, r[0]}); check(res_sel, r[1:0]);
		end
		wr(8'h00, 8'h04); check({heater_on, drive_en}, 2'b11);
		foreach (lvls[i]) begin
			wr(8'h08, {4'h0, lvls[i]}); check(htr_lvl, lvls[i]);
		end
		wr(8'h00, 8'h00); check({heater_on, drive_en}, 2'b00);
		$display("resolution and heater test done");
	endtask

	task automatic t_modes();
		for (int m = 0; m < 4; m++) begin
			wr(8'h04, {1'b0, m[1:0], 5'h0});
			check({mode, corr, nohold}, {m[1:0], m[0], m[1]});
		end
		wr(8'h04, 8'h00);
		@(posedge clk_sys);
		nh_cmd <= 1'b1;
		@(posedge clk_sys);
		#1;
		check(nohold, 1'b1);
		@(posedge clk_sys);
		nh_cmd <= 1'b0;
		wr(8'h04, 8'h17); check({speed, buf_en, ref_sel, pin_lvl}, 4'hf);
		$display("mode test done");
	endtask

	task automatic conv(input int exp_len);
		int n;
		n = 0;
		@(posedge clk_sys);
		req <= 1'b1;
		@(posedge clk_sys);
		req <= 1'b0;
		#1;
		while (busy === 1'b1 && n < 100) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		check(n, exp_len);
	endtask

	task automatic t_conv_irq();
		wr(8'h14, 8'h01);
		@(posedge clk_sys);
		sup_low <= 1'b1;
		repeat (4) @(posedge clk_sys);
		#1;
		check(irq, 1'b1);
		wr(8'h00, 8'h00); rd(8'h00); check(rdv, 32'h40);
		wr(8'h10, 8'h01); check(irq, 1'b0);
		conv(FAST);
		wr(8'h04, 8'h00);
		conv(SLOW);
		rd(8'h0c); check(rdv, 32'h2);
		check(irq, 1'b0);
		wr(8'h14, 8'h02); check(irq, 1'b1);
		rd(8'h14); check(rdv, 32'h2);
		wr(8'h10, 8'h02); check(irq, 1'b0);
		$display("converter and interrupt test done");
	endtask

	initial begin
		repeat (6) @(posedge clk_sys);
		sys_rst <= 1'b0;
		t_reset();
		t_res_heater();
		t_modes();
		t_conv_irq();
		summarize();
	end
endmodule
